// *** bench/snwp_core_asserts.sv ***
// Port checks for the write-protection core
`timescale 1ns/1ps
module snwp_core_asserts #(
   parameter int LOCKOUT_CYC = 1000,
   parameter int BUSY_CYC    = 16
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Pin and grants
   input wire logic wp_n,
   input wire logic program_grant,
   input wire logic erase_grant,
   input wire logic quad_grant,
   input wire logic otp_access,
   input wire logic pins_are_data,
   input wire logic busy
);
   int lock_cnt_q;
   int busy_cnt_q;
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         lock_cnt_q <= 0;
         busy_cnt_q <= 0;
      end
      else
      begin
         lock_cnt_q <= (lock_cnt_q < LOCKOUT_CYC) ? lock_cnt_q + 1 : lock_cnt_q;
         busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence s_grant;
      program_grant || erase_grant;
   endsequence
   sequence s_busy_run;
      busy [*8];
   endsequence
   AST_BUSY_START: assert property (s_grant |=> s_busy_run)
      else $error("busy did not follow a grant");
   AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_q == BUSY_CYC)
      else $error("busy length wrong");
   AST_BUSY_REFUSE: assert property (busy |-> !program_grant && !erase_grant)
      else $error("grant while busy");
   AST_GRANT_PULSE: assert property (s_grant |=> !program_grant && !erase_grant)
      else $error("grant longer than one cycle");
   AST_LOCKOUT: assert property (lock_cnt_q < LOCKOUT_CYC |-> !program_grant && !erase_grant)
      else $error("grant during lockout");
   AST_RESET_CLEAR: assert property ($fell(rst) |-> !busy && !otp_access && !program_grant)
      else $error("state not cleared by reset");
   AST_QUAD_HWP: assert property (quad_grant |-> pins_are_data)
      else $error("quad granted in hardware protect");
   AST_WP_BLOCK: assert property (!pins_are_data && $past(wp_n, 2) == 1'b0
      |-> !program_grant && !erase_grant)
      else $error("grant with protect pin low");
   AST_ONE_GRANT: assert property ($onehot0({program_grant, erase_grant, quad_grant}))
      else $error("two grants at once");
endmodule
bind snwp_core snwp_core_asserts #(.LOCKOUT_CYC(LOCKOUT_CYC), .BUSY_CYC(BUSY_CYC)) snwp_core_asserts_i (
   .clock(clock), .rst(rst), .wp_n(wp_n), .program_grant(program_grant),
   .erase_grant(erase_grant), .quad_grant(quad_grant), .otp_access(otp_access),
   .pins_are_data(pins_are_data), .busy(busy));

// *** bench/snwp_core_bench.sv ***
// Self-checking bench for the write-protection core
`timescale 1ns/1ps
`include "snwp_map.svh"
module snwp_core_bench;
   localparam int LOCK = 400;
   logic       clock, rst, cs_n, sclk, mosi, miso, wp_n, busy;
   logic       pg, eg, qg, rd_valid;
   logic [9:0] target_block;
   logic [7:0] rd_byte;
   logic [7:0] exp_q[$];
   logic       hold_n, target_otp, otp_access, pins_are_data, hold_active;
   int         fail_count, cmp_count, blk_n;
   snwp_core #(.LOCKOUT_CYC(LOCK), .BUSY_CYC(16)) snwp_core_i (
      .clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
      .wp_n(wp_n), .hold_n(hold_n), .target_block(target_block), .target_otp(target_otp),
      .program_grant(pg), .erase_grant(eg), .quad_grant(qg), .otp_access(otp_access),
      .pins_are_data(pins_are_data), .hold_active(hold_active), .busy(busy));
   snwp_host snwp_host_i (
      .clock(clock), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
      .rd_valid(rd_valid), .rd_byte(rd_byte));
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic check_pin(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t pin got %b want %b", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Each read byte or grant takes the oldest expectation
   always @(posedge clock)
      if (!rst && (rd_valid || pg || eg || qg))
         check(rd_valid ? rd_byte : pg ? `SNWP_OP_PEXEC : eg ? `SNWP_OP_ERASE : `SNWP_OP_QREAD_A,
               exp_q.size() ? exp_q.pop_front() : 8'hxx);
   task automatic cmd(input logic [7:0] op);
      snwp_host_i.frame({op, 16'h0000}, 1, 1'b0);
   endtask
   task automatic go(input logic [7:0] op);
      int i;
      exp_q.push_back(op);
      cmd(op);
      for (i = 0; i < 200 && busy !== 1'b0; i++)
         @(negedge clock);
      if (busy !== 1'b0)
         check(8'h01, 8'h00);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      snwp_host_i.frame({(a == 8'hb0) ? `SNWP_OP_RDSR_B : `SNWP_OP_RDSR_A, a, 8'h00}, 3, 1'b1);
   endtask
   task automatic wr(input logic [7:0] v);
      cmd(`SNWP_OP_WREN);
      snwp_host_i.frame({`SNWP_OP_WRSR_A, 8'ha0, v}, 3, 1'b0);
   endtask
   initial
   begin
      rst = 1'b1;
      wp_n = 1'b1;
      hold_n = 1'b1;
      target_otp = 1'b0;
      target_block = 10'h3ff;
      fail_count = 0;
      cmp_count = 0;
      blk_n = $urandom(32'h6584);
      blk_n = 1 + $urandom % 9;
      repeat (20) @(negedge clock);
      rst = 1'b0;
      cmd(`SNWP_OP_WREN);
      rd(8'hc0, 8'h00);
      rd(8'ha0, `SNWP_PROT_RESET);
      rd(8'hb0, `SNWP_CONF_RESET);
      cmd(`SNWP_OP_PEXEC);
      cmd(`SNWP_OP_WREN);
      rd(8'hc0, 8'h02);
      cmd(`SNWP_OP_PEXEC);
      rd(8'hc0, 8'h02);
      wr({1'b0, blk_n[3:0], 3'b000});
      rd(8'ha0, {1'b0, blk_n[3:0], 3'b000});
      cmd(`SNWP_OP_WREN);
      cmd(`SNWP_OP_PEXEC);
      target_block = 10'($urandom % (1024 - (1 << blk_n)));
      go(`SNWP_OP_PEXEC);
      rd(8'hc0, 8'h00);
      cmd(`SNWP_OP_WREN);
      go(`SNWP_OP_ERASE);
      go(`SNWP_OP_QREAD_A);
      check_pin(pins_are_data, 1'b1);
      wr(8'h02);
      check_pin(pins_are_data, 1'b0);
      hold_n = 1'b0;
      fork
         cmd(`SNWP_OP_QREAD_A);
         begin
            repeat (100) @(negedge clock);
            check_pin(hold_active, 1'b1);
         end
      join
      check_pin(hold_active, 1'b0);
      hold_n = 1'b1;
      wp_n = 1'b0;
      cmd(`SNWP_OP_WREN);
      cmd(`SNWP_OP_ERASE);
      wr(8'h00);
      rd(8'ha0, 8'h02);
      wp_n = 1'b1;
      wr(8'h01);
      rd(8'ha0, 8'h01);
      check_pin(pins_are_data, 1'b1);
      wp_n = 1'b0;
      wr(8'h7c);
      rd(8'ha0, 8'h01);
      wp_n = 1'b1;
      wr(8'h80);
      wr(8'h00);
      rd(8'ha0, 8'h80);
      snwp_host_i.frame({`SNWP_OP_WRSR_B, 8'hb0, 8'h20}, 3, 1'b0);
      check_pin(otp_access, 1'b1);
      cmd(`SNWP_OP_RESET);
      check_pin(otp_access, 1'b0);
      rst = 1'b1;
      repeat (20) @(negedge clock);
      rst = 1'b0;
      repeat (LOCK) @(negedge clock);
      rd(8'ha0, `SNWP_PROT_RESET);
      rd(8'hb0, `SNWP_CONF_RESET);
      wr(8'h81);
      snwp_host_i.frame({`SNWP_OP_WRSR_B, 8'hb0, 8'h20}, 3, 1'b0);
      target_otp = 1'b1;
      cmd(`SNWP_OP_WREN);
      go(`SNWP_OP_PEXEC);
      snwp_host_i.frame({`SNWP_OP_WRSR_B, 8'hb0, 8'he0}, 3, 1'b0);
      rd(8'hb0, 8'he0);
      cmd(`SNWP_OP_WREN);
      cmd(`SNWP_OP_PEXEC);
      wr(8'h00);
      rd(8'ha0, 8'h81);
      repeat (20) @(negedge clock);
      check(8'(exp_q.size()), 8'h00);
      print_verdict();
   end
endmodule

// *** bench/snwp_host.sv ***
// Serial host model framing commands on the link pins
`timescale 1ns/1ps
module snwp_host
(
   // Bench clock
   input  wire logic clock,
   // Link pins
   output logic       cs_n,
   output logic       sclk,
   output logic       mosi,
   input  wire logic  miso,
   // Read result
   output logic       rd_valid,
   output logic [7:0] rd_byte
);
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      rd_valid = 1'b0;
      rd_byte = 8'h00;
   end
   // opcode, address byte, data byte in one frame
   task automatic frame(input logic [23:0] d, input int n, input bit ret);
      int i;
      @(negedge clock);
      cs_n = 1'b0;
      for (i = 0; i < 8 * n; i++)
      begin
         mosi = d[23 - i];
         repeat (13) @(negedge clock);
         sclk = 1'b1;
         rd_byte = {rd_byte[6:0], miso};
         repeat (12) @(negedge clock);
         sclk = 1'b0;
      end
      repeat (13) @(negedge clock);
      cs_n = 1'b1;
      mosi = ~mosi;
      rd_valid = ret;
      @(negedge clock);
      rd_valid = 1'b0;
      repeat (50) @(negedge clock);
   endtask
endmodule

// *** hdl/snwp_core.sv ***
// Write-enable latch, block and register protection, OTP lock and quad gating
`timescale 1ns/1ps
`include "snwp_map.svh"
module snwp_core #(
   parameter int LOCKOUT_CYC = `SNWP_LOCKOUT_CYC,
   parameter int BUSY_CYC    = `SNWP_BUSY_CYC
)
(
   // Clock and reset (reset stands for power cycle)
   input  wire logic        clock,
   input  wire logic        rst,
   // Serial link pins
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        mosi,
   output logic             miso,
   input  wire logic        wp_n,
   input  wire logic        hold_n,
   // Array side: protected-region query and grants
   input  wire logic [9:0]  target_block,
   input  wire logic        target_otp,
   output logic             program_grant,
   output logic             erase_grant,
   output logic             quad_grant,
   output logic             otp_access,
   output logic             pins_are_data,
   output logic             hold_active,
   output logic             busy
);
   // Counts below one cannot be served
   if (LOCKOUT_CYC < 1 || BUSY_CYC < 1)
   begin
      $error("snwp_core: counts must be at least one");
   end

   // Pin synchronisers
   logic [1:0] cs_sy_q;
   logic [1:0] ck_sy_q;
   logic [1:0] mo_sy_q;
   logic [1:0] wp_sy_q;
   logic [1:0] hd_sy_q;
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cs_sy_q <= 2'b11;
         ck_sy_q <= 2'b00;
         mo_sy_q <= 2'b00;
         wp_sy_q <= 2'b11;
         hd_sy_q <= 2'b11;
      end
      else
      begin
         cs_sy_q <= {cs_sy_q[0], cs_n};
         ck_sy_q <= {ck_sy_q[0], sclk};
         mo_sy_q <= {mo_sy_q[0], mosi};
         wp_sy_q <= {wp_sy_q[0], wp_n};
         hd_sy_q <= {hd_sy_q[0], hold_n};
      end
   end
   wire cs_n_s = cs_sy_q[1];
   wire wp_n_s = wp_sy_q[1];

   logic                 byte_valid;
   snwp_pkg::snwp_byte_t byte_data;
   logic                 frame_start;
   snwp_pkg::snwp_byte_t tx_byte;
   logic                 tx_load;
   snwp_spi_rx u_rx (
      .clock       (clock),
      .rst         (rst),
      .cs_n_s      (cs_n_s),
      .sclk_s      (ck_sy_q[1]),
      .mosi_s      (mo_sy_q[1]),
      .byte_valid  (byte_valid),
      .byte_data   (byte_data),
      .frame_start (frame_start),
      .tx_byte     (tx_byte),
      .tx_load     (tx_load),
      .miso        (miso)
   );

   // State
   logic [7:0]  prot_q;
   logic [7:0]  lock_val_q  = `SNWP_PROT_RESET;
   logic        prot_lock_q = 1'b0;
   logic        otp_lock_q  = 1'b0;
   logic        otp_en_q;
   logic [1:0]  conf_lo_q;
   logic        wr_latch_q;
   logic [31:0] lock_cnt_q;
   logic [31:0] busy_cnt_q;
   logic        op_prog_q;
   logic        first_q;
   logic [7:0]  op_q;
   logic [3:0]  addr_q;
   snwp_pkg::snwp_phase_e phase_q;

   function automatic logic is_op(input logic [7:0] b, input logic [7:0] a,
                                  input logic [7:0] c);
      is_op = (b == a) || (b == c);
   endfunction

   // Region protected by block-protect and top/bottom: 2^n blocks from one end, all 1024 when n is 10 or more, none when n is 0
   function automatic logic blk_protected(input logic [7:0] p, input logic [9:0] blk);
      logic [3:0]  blk_bits;
      logic [10:0] span;
      logic [9:0]  idx;
      blk_bits = p[`SNWP_BIT_BLK_PROT_LO +: 4];
      idx = p[`SNWP_BIT_TOP_BOTTOM] ? blk : (10'h3ff - blk);
      span = (blk_bits == 4'h0) ? 11'h000 :
             (blk_bits >= 4'hb) ? 11'h400 : (11'h001 << blk_bits);
      blk_protected = ({1'b0, idx} < span);
   endfunction

   wire lockout   = (lock_cnt_q != 32'h0);
   wire wpe       = prot_q[`SNWP_BIT_WPE];
   wire sp_lo     = prot_q[`SNWP_BIT_STAT_PROT_LO];
   wire sp_hi     = prot_q[`SNWP_BIT_STAT_PROT_HI];
   // Hardware protect, pin low
   wire hw_block  = wpe & ~wp_n_s;
   wire in_busy   = (busy_cnt_q != 32'h0);
   // Status protect modes on protection register
   wire sw_pin_lk = ~wpe & ~sp_hi & sp_lo & ~wp_n_s;
   wire pwr_lk    = sp_hi & ~sp_lo;
   wire prot_wr_ok = ~prot_lock_q & ~pwr_lk & ~sw_pin_lk & ~hw_block;
   wire lock_allow = sp_hi & sp_lo & otp_en_q;
   wire region_ok = target_otp ? (otp_en_q & ~otp_lock_q)
                               : ~blk_protected(prot_q, target_block);
   wire cmd_ok    = wr_latch_q & ~hw_block & ~in_busy & ~lockout & region_ok;
   wire [7:0] conf_rd = {otp_lock_q, prot_lock_q, otp_en_q, 3'h0, conf_lo_q};
   wire [7:0] stat_rd = {6'h00, wr_latch_q, in_busy};
   // Reply is loaded while the address byte itself is on byte_data
   wire [3:0] rd_addr = byte_data[7:4];
   wire [7:0] rd_sel = (rd_addr == `SNWP_ADDR_PROT) ? prot_q :
                       (rd_addr == `SNWP_ADDR_CONF) ? conf_rd :
                       (rd_addr == `SNWP_ADDR_STAT) ? stat_rd : 8'h00;
   wire op_byte   = byte_valid & first_q;
   wire is_wrsr   = is_op(op_q, `SNWP_OP_WRSR_A, `SNWP_OP_WRSR_B);
   wire is_quad   = is_op(byte_data, `SNWP_OP_QLOAD_A, `SNWP_OP_QLOAD_B)
                  | is_op(byte_data, `SNWP_OP_QREAD_A, `SNWP_OP_QREAD_B);
   wire is_pe     = is_op(byte_data, `SNWP_OP_PEXEC, `SNWP_OP_ERASE);
   wire do_wrsr   = byte_valid & (phase_q == snwp_pkg::SNWP_DATA) & is_wrsr;
   wire byte_ne_a = ~lockout & ~hw_block & ~in_busy;

   assign tx_byte = rd_sel;
   assign tx_load = byte_valid & (phase_q == snwp_pkg::SNWP_ADDR) & ~is_wrsr;
   assign quad_grant = op_byte & is_quad & ~wpe;
   // pins are data lines only when hardware protect is off
   assign pins_are_data = ~wpe;
   assign hold_active = wpe & ~hd_sy_q[1] & ~cs_n_s;
   // OTP reachable only while access bit set
   assign otp_access = otp_en_q;
   // busy flag shown in status byte
   assign busy = in_busy;
   assign program_grant = op_byte & (byte_data == `SNWP_OP_PEXEC) & cmd_ok;
   assign erase_grant   = op_byte & (byte_data == `SNWP_OP_ERASE) & cmd_ok & ~target_otp;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         first_q <= 1'b0;
         phase_q <= snwp_pkg::SNWP_IDLE;
         op_q <= 8'h00;
         addr_q <= 4'h0;
      end
      else if (frame_start)
      begin
         first_q <= 1'b1;
         phase_q <= snwp_pkg::SNWP_IDLE;
      end
      else if (byte_valid)
      begin
         first_q <= 1'b0;
         case (phase_q)
            snwp_pkg::SNWP_IDLE:
            begin
               op_q <= byte_data;
               phase_q <= (first_q & (is_op(byte_data, `SNWP_OP_RDSR_A, `SNWP_OP_RDSR_B)
                          | is_op(byte_data, `SNWP_OP_WRSR_A, `SNWP_OP_WRSR_B)))
                          ? snwp_pkg::SNWP_ADDR : snwp_pkg::SNWP_SKIP;
            end
            snwp_pkg::SNWP_ADDR:
            begin
               addr_q <= byte_data[7:4];
               phase_q <= snwp_pkg::SNWP_DATA;
            end
            snwp_pkg::SNWP_DATA: phase_q <= snwp_pkg::SNWP_SKIP;
            snwp_pkg::SNWP_SKIP: phase_q <= snwp_pkg::SNWP_SKIP;
            default: phase_q <= snwp_pkg::SNWP_SKIP;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         lock_cnt_q <= 32'(LOCKOUT_CYC);
      else if (lockout)
         lock_cnt_q <= lock_cnt_q - 32'h1;
   end

   // busy count for program and erase
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         busy_cnt_q <= 32'h0;
         op_prog_q <= 1'b0;
      end
      else if (program_grant | erase_grant)
      begin
         busy_cnt_q <= 32'(BUSY_CYC);
         op_prog_q <= 1'b1;
      end
      else if (in_busy)
         busy_cnt_q <= busy_cnt_q - 32'h1;
      else
         op_prog_q <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         wr_latch_q <= 1'b0;
      else if (op_prog_q & (busy_cnt_q == 32'h1))
         wr_latch_q <= 1'b0;
      else if (op_byte & (byte_data == `SNWP_OP_WREN) & byte_ne_a)
         wr_latch_q <= 1'b1;
      else if (op_byte & (byte_data == `SNWP_OP_WRDI))
         wr_latch_q <= 1'b0;
   end

   // all block-protect bits set at reset
   // power cycle returns protect bits to 00, then to the locked value after lockout if protection lock is set
   // status protect at bits 0 and 7
   // protect fields writable via write status
   always_ff @(posedge clock)
   begin
      if (rst)
         prot_q <= `SNWP_PROT_RESET;
      else if (lock_cnt_q == 32'h1 && prot_lock_q)
         prot_q <= lock_val_q;
      else if (do_wrsr && addr_q == `SNWP_ADDR_PROT && prot_wr_ok && !lockout)
         prot_q <= byte_data;
   end

   // lock needs protect 11 and OTP access
   // OTP lock set once, never cleared
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         otp_en_q <= 1'b0;
         conf_lo_q <= 2'b00;
      end
      else if (do_wrsr && addr_q == `SNWP_ADDR_CONF && !hw_block && !lockout)
      begin
         otp_en_q <= byte_data[`SNWP_BIT_OTP_EN];
         conf_lo_q <= byte_data[1:0];
      end
      else if (op_byte && byte_data == `SNWP_OP_RESET)
         otp_en_q <= 1'b0;
   end

   // Permanent bits: not cleared by reset, only by the first power-up
   always_ff @(posedge clock)
   begin
      if (!rst && do_wrsr && addr_q == `SNWP_ADDR_CONF && !hw_block && !lockout)
      begin
         if (byte_data[`SNWP_BIT_PROT_LOCK] && lock_allow && !prot_lock_q)
         begin
            prot_lock_q <= 1'b1;
            lock_val_q <= prot_q;
         end
         if (byte_data[`SNWP_BIT_OTP_LOCK] && otp_en_q)
            otp_lock_q <= 1'b1;
      end
   end
endmodule

// *** hdl/snwp_map.svh ***
// Register addresses, field positions, reset values and timing counts for write protection
`ifndef SNWP_MAP_SVH
`define SNWP_MAP_SVH
`define SNWP_OP_WREN        8'h06
`define SNWP_OP_WRDI        8'h04
`define SNWP_OP_RDSR_A      8'h05
`define SNWP_OP_RDSR_B      8'h0f
`define SNWP_OP_WRSR_A      8'h01
`define SNWP_OP_WRSR_B      8'h1f
`define SNWP_OP_RESET       8'hff
`define SNWP_OP_BBM         8'ha1
`define SNWP_OP_PEXEC       8'h10
`define SNWP_OP_ERASE       8'hd8
`define SNWP_OP_QLOAD_A     8'h32
`define SNWP_OP_QLOAD_B     8'h34
`define SNWP_OP_QREAD_A     8'h6b
`define SNWP_OP_QREAD_B     8'heb
`define SNWP_OP_READ        8'h13
`define SNWP_ADDR_PROT      4'ha
`define SNWP_ADDR_CONF      4'hb
`define SNWP_ADDR_STAT      4'hc
`define SNWP_BIT_STAT_PROT_LO 0
`define SNWP_BIT_WPE          1
`define SNWP_BIT_TOP_BOTTOM   2
`define SNWP_BIT_BLK_PROT_LO  3
`define SNWP_BIT_STAT_PROT_HI 7
`define SNWP_BIT_OTP_LOCK     7
`define SNWP_BIT_PROT_LOCK    6
`define SNWP_BIT_OTP_EN       5
`define SNWP_BIT_BUSY         0
`define SNWP_BIT_WR_LATCH     1
`define SNWP_PROT_RESET     8'h7c
`define SNWP_CONF_RESET     8'h00
`define SNWP_CONF_WMASK     8'he0
`define SNWP_OTP_PAGES      10
`define SNWP_OTP_PAGE_BYTES 2112
`define SNWP_LOCKOUT_US     5
`define SNWP_CLK_MHZ        200
`define SNWP_LOCKOUT_CYC    (`SNWP_LOCKOUT_US * `SNWP_CLK_MHZ)
`define SNWP_BUSY_CYC       16
`endif

// *** hdl/snwp_pkg.sv ***
// Types shared by the write-protection logic
package snwp_pkg;
   typedef enum logic [1:0] {
      SNWP_IDLE,
      SNWP_ADDR,
      SNWP_DATA,
      SNWP_SKIP
   } snwp_phase_e;
   typedef logic [7:0] snwp_byte_t;
endpackage

// *** hdl/snwp_spi_rx.sv ***
// Serial byte receiver and status shifter on the sampled serial clock
`timescale 1ns/1ps
`include "snwp_map.svh"
module snwp_spi_rx
(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // Synchronised link pins
   input  wire logic              cs_n_s,
   input  wire logic              sclk_s,
   input  wire logic              mosi_s,
   // Byte out and byte to send
   output logic                   byte_valid,
   output snwp_pkg::snwp_byte_t   byte_data,
   output logic                   frame_start,
   input  wire snwp_pkg::snwp_byte_t tx_byte,
   input  wire logic              tx_load,
   output logic                   miso
);
   logic       sclk_prev_q;
   logic [2:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic       cs_prev_q;
   logic       miso_q;
   logic       byte_valid_q;
   logic [7:0] byte_data_q;
   wire        rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
   wire        fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
   wire [7:0]  sh_next = {sh_q[6:0], mosi_s};
   assign frame_start = cs_prev_q & ~cs_n_s;
   assign byte_valid = byte_valid_q;
   assign byte_data = byte_data_q;
   assign miso = miso_q;
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         miso_q <= 1'b0;
         byte_valid_q <= 1'b0;
         byte_data_q <= 8'h00;
      end
      else
      begin
         sclk_prev_q <= sclk_s;
         cs_prev_q <= cs_n_s;
         byte_valid_q <= 1'b0;
         if (cs_n_s)
            cnt_q <= 3'h0;
         else if (rise)
         begin
            sh_q <= sh_next;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7)
            begin
               byte_valid_q <= 1'b1;
               byte_data_q <= sh_next;
            end
         end
         if (tx_load)
            tx_q <= tx_byte;
         else if (fall)
         begin
            miso_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end
endmodule
